/* File: hdl/rw_turn_defines.svh */
// Purpose: Constants for the read/write turnaround and write fault tracker.
// Assumes: Included by bare name; holds definitions only.
// Notes: Burst mode encodings follow the two-bit burst mode field.
`ifndef RW_TURN_DEFINES_SVH
`define RW_TURN_DEFINES_SVH

`define BMODE_FIXED_BL8 2'h0
`define BMODE_PER_CMD 2'h1
`define BMODE_FIXED_BC4 2'h2
`define BURST_TERM_LONG 4'h8
`define BURST_TERM_CHOP 4'h4
`define TOL_EDGE_LIMIT 4'h6
`define READ_TO_WRITE_EXTRA 7'h01
`define PREAMBLE_1T 7'h01
`define PREAMBLE_2T 7'h02
`define LAT_W 5
`define TURN_W 7
`define BANK_COUNT 8

`endif

/* File: hdl/rw_turn_pkg.sv */
// Purpose: Types shared by the turnaround and write fault tracker.
// Assumes: Command codes arrive already decoded from the command pins.
// Notes: Recovery states are Gray coded along clean, suspect, draining.
package rw_turn_pkg;

	typedef enum logic [2:0]
	{
		CMD_DES = 3'h0,
		CMD_ACT = 3'h1,
		CMD_RD = 3'h2,
		CMD_RDA = 3'h3,
		CMD_WR = 3'h4,
		CMD_WRA = 3'h5,
		CMD_PRE = 3'h6,
		CMD_PREA = 3'h7
	} cmd_e;

	typedef enum logic [1:0]
	{
		REC_CLEAN = 2'h0,
		REC_SUSPECT = 2'h1,
		REC_DRAINING = 2'h3
	} rec_state_e;

endpackage : rw_turn_pkg

/* File: hdl/level_sync.sv */
// Purpose: Two flip-flop synchroniser for independent level bits.
// Assumes: Each bit is a level or a toggle, never a multi-bit word that must stay coherent.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module level_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= i_async;
			sync_reg <= meta_reg;
		end
	end

	assign o_sync = sync_reg;
endmodule : level_sync

/* File: hdl/rw_turn_tracker.sv */
// Purpose: Device-side write burst tracker with turnaround figures and write fault recovery.
// Assumes: Link logic runs on the command clock i_ck; configuration changes only while idle.
// Notes: Additive latency is taken as zero; bank index is bank group then bank address.
// What this block does
// - Write recovery starts at first rising clock edge after the final data beat.
// - In per-command mode, A12 high gives an 8-beat read, low a chop; writes stay 8-beat.
// - In fixed chop mode every write is a four-beat chop.
// - Data-to-strobe offset faults may corrupt data but the device keeps working.
// - Strobe and strobe-to-clock faults keep the device working only with CRC off, a fixed burst mode, no other fault and at most 6 edges of shift.
// - Reads to any open bank after an offending write are accepted.
// - Further writes to the same bank after tCCD_L are accepted, data may be wrong.
// - Further writes to another bank group after tCCD_S are accepted.
// - Once precharges leave all banks idle, later clean writes store correct data.
`timescale 1ns/1ns
`include "rw_turn_defines.svh"
module rw_turn_tracker #(
	parameter int PIPE_DEPTH = 40
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ck,
	input wire logic i_cmd_valid,
	input wire rw_turn_pkg::cmd_e i_cmd,
	input wire logic [2:0] i_bank,
	input wire logic i_a12,
	input wire logic i_dq_offset_fault,
	input wire logic i_strobe_fault,
	input wire logic [3:0] i_strobe_shift_edges,
	input wire logic i_other_fault,
	input wire logic [1:0] i_burst_mode,
	input wire logic [`LAT_W-1:0] i_cas_lat,
	input wire logic [`LAT_W-1:0] i_cas_wr_lat,
	input wire logic i_wr_preamble_2t,
	input wire logic i_wr_crc_en,
	input wire logic [3:0] i_twtr_s_clks,
	output logic o_wr_recovery_start,
	output logic [3:0] o_rd_burst_term,
	output logic [3:0] o_wr_burst_term,
	output logic [`TURN_W-1:0] o_rd_to_wr_min_clks,
	output logic [`TURN_W-1:0] o_wr_to_rd_min_clks,
	output logic o_write_suspect,
	output logic o_reinit_required,
	output logic o_banks_idle
);
	import rw_turn_pkg::*;

	// Configuration crossing into the command clock domain.
	logic [1:0] ck_mode;
	logic [`LAT_W-1:0] ck_cwl;
	logic ck_crc_en;

	level_sync #(.W(2 + `LAT_W + 1)) u_cfg_sync (
		.i_clk(i_ck),
		.i_rst_n(i_rst_n),
		.i_async({i_burst_mode, i_cas_wr_lat, i_wr_crc_en}),
		.o_sync({ck_mode, ck_cwl, ck_crc_en})
	);

	// Command clock domain state.
	logic [PIPE_DEPTH-1:0] end_pipe_reg, end_pipe_next;
	logic done_tgl_reg, done_tgl_next;
	logic rd_chop_reg, rd_chop_next;
	logic wr_chop_reg, wr_chop_next;
	logic [`BANK_COUNT-1:0] open_reg, open_next;
	rec_state_e rec_reg, rec_next;
	logic reinit_reg, reinit_next;
	logic susp_ck_reg, susp_ck_next;
	logic busy_ck_reg, busy_ck_next;

	logic is_wr, is_rd, cmd_chop, burst_live, tol_strobe, fault_now;
	logic [`LAT_W:0] end_index;

	always_comb
	begin
		is_wr = i_cmd_valid && (i_cmd == CMD_WR || i_cmd == CMD_WRA);
		is_rd = i_cmd_valid && (i_cmd == CMD_RD || i_cmd == CMD_RDA);
		if (ck_mode == `BMODE_FIXED_BC4)
			cmd_chop = 1'b1;
		else if (ck_mode == `BMODE_PER_CMD)
			cmd_chop = !i_a12;
		else
			cmd_chop = 1'b0;
		// Only the fixed chop mode ends two clocks early; a per-command chop keeps the long recovery slot.
		end_index = {1'b0, ck_cwl} + ((ck_mode == `BMODE_FIXED_BC4) ? 6'h02 : 6'h04);
		burst_live = |end_pipe_reg;
		// Strobe faults are forgiven only inside this narrow window.
		tol_strobe = !ck_crc_en && ck_mode != `BMODE_PER_CMD && !i_other_fault
			&& i_strobe_shift_edges <= `TOL_EDGE_LIMIT;
		// Any write fault leaves the stored data in doubt, whether or not it is forgiven.
		fault_now = burst_live && (i_dq_offset_fault || i_strobe_fault || i_other_fault);

		end_pipe_next = end_pipe_reg >> 1;
		if (is_wr && end_index < PIPE_DEPTH)
			end_pipe_next[end_index] = 1'b1;
		done_tgl_next = done_tgl_reg ^ end_pipe_reg[0];

		rd_chop_next = rd_chop_reg;
		wr_chop_next = wr_chop_reg;
		if (is_rd)
			rd_chop_next = cmd_chop;
		if (is_wr)
			wr_chop_next = ck_mode == `BMODE_FIXED_BC4;

		// Reads and writes are never blocked by a prior fault.
		open_next = open_reg;
		if (i_cmd_valid)
		begin
			case (i_cmd)
				CMD_ACT: open_next[i_bank] = 1'b1;
				CMD_RDA, CMD_WRA, CMD_PRE: open_next[i_bank] = 1'b0;
				CMD_PREA: open_next = '0;
				default: open_next = open_reg;
			endcase
		end

		reinit_next = reinit_reg;
		rec_next = rec_reg;
		if (burst_live && (i_other_fault || (i_strobe_fault && !tol_strobe)))
			reinit_next = 1'b1;
		case (rec_reg)
			REC_CLEAN:
				if (fault_now)
					rec_next = REC_SUSPECT;
			REC_SUSPECT:
				// A fault in the same cycle as a precharge wins, so the burst stays suspect.
				if (!fault_now && i_cmd_valid
					&& (i_cmd == CMD_PRE || i_cmd == CMD_PREA || i_cmd == CMD_RDA || i_cmd == CMD_WRA))
					rec_next = REC_DRAINING;
			REC_DRAINING:
				if (fault_now)
					rec_next = REC_SUSPECT;
				else if (open_reg == '0 && !burst_live)
					rec_next = REC_CLEAN;
			default:
				rec_next = REC_CLEAN;
		endcase
		// Flags are registered before they cross, so no decode glitch reaches the synchroniser.
		susp_ck_next = rec_next != REC_CLEAN;
		busy_ck_next = open_next != '0;
	end

	always_ff @(posedge i_ck or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			end_pipe_reg <= '0;
			done_tgl_reg <= 1'b0;
			rd_chop_reg <= 1'b0;
			wr_chop_reg <= 1'b0;
			open_reg <= '0;
			rec_reg <= REC_CLEAN;
			reinit_reg <= 1'b0;
			susp_ck_reg <= 1'b0;
			busy_ck_reg <= 1'b0;
		end
		else
		begin
			end_pipe_reg <= end_pipe_next;
			done_tgl_reg <= done_tgl_next;
			rd_chop_reg <= rd_chop_next;
			wr_chop_reg <= wr_chop_next;
			open_reg <= open_next;
			rec_reg <= rec_next;
			reinit_reg <= reinit_next;
			susp_ck_reg <= susp_ck_next;
			busy_ck_reg <= busy_ck_next;
		end
	end

	// Status crossing back to the system clock; the done event travels as a toggle.
	// Busy rather than idle crosses, so the synchroniser's reset value agrees with the idle output's.
	logic s_done_tgl, s_rd_chop, s_wr_chop, s_suspect, s_reinit, s_busy;

	level_sync #(.W(6)) u_stat_sync (
		.i_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_async({done_tgl_reg, rd_chop_reg, wr_chop_reg, susp_ck_reg, reinit_reg, busy_ck_reg}),
		.o_sync({s_done_tgl, s_rd_chop, s_wr_chop, s_suspect, s_reinit, s_busy})
	);

	// System clock domain state.
	logic done_seen_reg, done_seen_next;
	logic recov_reg, recov_next;
	logic [3:0] rbl_reg, rbl_next;
	logic [3:0] wbl_reg, wbl_next;
	logic [`TURN_W-1:0] r2w_reg, r2w_next;
	logic [`TURN_W-1:0] w2r_reg, w2r_next;
	logic suspect_reg, suspect_next;
	logic reinit_out_reg, reinit_out_next;
	logic idle_reg, idle_next;

	always_comb
	begin
		done_seen_next = s_done_tgl;
		recov_next = s_done_tgl ^ done_seen_reg;
		rbl_next = s_rd_chop ? `BURST_TERM_CHOP : `BURST_TERM_LONG;
		wbl_next = s_wr_chop ? `BURST_TERM_CHOP : `BURST_TERM_LONG;
		// The controller is expected to allow the longer calibration times with these minima.
		r2w_next = {2'h0, i_cas_lat} - {2'h0, i_cas_wr_lat} + {4'h0, rbl_reg[3:1]}
			+ `READ_TO_WRITE_EXTRA + (i_wr_preamble_2t ? `PREAMBLE_2T : `PREAMBLE_1T);
		w2r_next = {2'h0, i_cas_wr_lat} + {4'h0, wbl_reg[3:1]} + {3'h0, i_twtr_s_clks};
		suspect_next = s_suspect;
		reinit_out_next = s_reinit;
		idle_next = !s_busy;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			done_seen_reg <= 1'b0;
			recov_reg <= 1'b0;
			rbl_reg <= `BURST_TERM_LONG;
			wbl_reg <= `BURST_TERM_LONG;
			r2w_reg <= '0;
			w2r_reg <= '0;
			suspect_reg <= 1'b0;
			reinit_out_reg <= 1'b0;
			idle_reg <= 1'b1;
		end
		else
		begin
			done_seen_reg <= done_seen_next;
			recov_reg <= recov_next;
			rbl_reg <= rbl_next;
			wbl_reg <= wbl_next;
			r2w_reg <= r2w_next;
			w2r_reg <= w2r_next;
			suspect_reg <= suspect_next;
			reinit_out_reg <= reinit_out_next;
			idle_reg <= idle_next;
		end
	end

	assign o_wr_recovery_start = recov_reg;
	assign o_rd_burst_term = rbl_reg;
	assign o_wr_burst_term = wbl_reg;
	assign o_rd_to_wr_min_clks = r2w_reg;
	assign o_wr_to_rd_min_clks = w2r_reg;
	assign o_write_suspect = suspect_reg;
	assign o_reinit_required = reinit_out_reg;
	assign o_banks_idle = idle_reg;
endmodule : rw_turn_tracker

/* File: tb/rw_turn_monitor.sv */
// Purpose: Port checks for the turnaround tracker.
// Assumes: Config only moves while the link is idle.
// Notes: Only the system clock domain is checked.
`timescale 1ns/1ns
module rw_turn_monitor #(
	parameter int PIPE_DEPTH = 40
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [4:0] i_cas_lat,
	input wire logic [4:0] i_cas_wr_lat,
	input wire logic i_wr_preamble_2t,
	input wire logic [3:0] i_twtr_s_clks,
	input wire logic [1:0] i_burst_mode,
	input wire logic o_wr_recovery_start,
	input wire logic [3:0] o_rd_burst_term,
	input wire logic [3:0] o_wr_burst_term,
	input wire logic [6:0] o_rd_to_wr_min_clks,
	input wire logic [6:0] o_wr_to_rd_min_clks,
	input wire logic o_write_suspect,
	input wire logic o_reinit_required,
	input wire logic o_banks_idle
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// The outputs are in the stable set too, so the reset values seen just after release never match.
	sequence s_still;
		$stable({i_cas_lat, i_cas_wr_lat, i_wr_preamble_2t, i_twtr_s_clks, o_rd_burst_term, o_wr_burst_term,
			o_rd_to_wr_min_clks, o_wr_to_rd_min_clks})[*3];
	endsequence
	property p_rd2wr; s_still |-> o_rd_to_wr_min_clks == 7'(i_cas_lat - i_cas_wr_lat + o_rd_burst_term / 2 + 2 + i_wr_preamble_2t); endproperty
	property p_wr2rd; s_still |-> o_wr_to_rd_min_clks == i_cas_wr_lat + o_wr_burst_term / 2 + i_twtr_s_clks; endproperty
	property p_rd_term; o_rd_burst_term == 4'h8 || (o_rd_burst_term == 4'h4 && i_burst_mode != 2'h0); endproperty
	property p_wr_chop; o_wr_burst_term == 4'h4 |-> i_burst_mode == 2'h2; endproperty
	property p_pulse; o_wr_recovery_start |=> !o_wr_recovery_start; endproperty
	property p_sticky; o_reinit_required |=> o_reinit_required; endproperty
	property p_clean; $fell(o_write_suspect) |-> o_banks_idle; endproperty
	property p_fault; $rose(o_reinit_required) |-> ##[0:2] o_write_suspect; endproperty
	a_rd2wr: assert property (p_rd2wr) else $error("read to write spacing wrong");
	a_wr2rd: assert property (p_wr2rd) else $error("write to read spacing wrong");
	a_rd_term: assert property (p_rd_term) else $error("read term wrong");
	a_wr_chop: assert property (p_wr_chop) else $error("write term wrong");
	a_pulse: assert property (p_pulse) else $error("recovery pulse too long");
	a_sticky: assert property (p_sticky) else $error("reinit dropped");
	a_clean: assert property (p_clean) else $error("suspect cleared early");
	a_fault: assert property (p_fault) else $error("reinit without suspect");
endmodule : rw_turn_monitor

bind rw_turn_tracker rw_turn_monitor #(.PIPE_DEPTH(PIPE_DEPTH)) u_mon (
	.i_sys_clk(i_sys_clk),
	.i_rst_n(i_rst_n),
	.i_cas_lat(i_cas_lat),
	.i_cas_wr_lat(i_cas_wr_lat),
	.i_wr_preamble_2t(i_wr_preamble_2t),
	.i_twtr_s_clks(i_twtr_s_clks),
	.i_burst_mode(i_burst_mode),
	.o_wr_recovery_start(o_wr_recovery_start),
	.o_rd_burst_term(o_rd_burst_term),
	.o_wr_burst_term(o_wr_burst_term),
	.o_rd_to_wr_min_clks(o_rd_to_wr_min_clks),
	.o_wr_to_rd_min_clks(o_wr_to_rd_min_clks),
	.o_write_suspect(o_write_suspect),
	.o_reinit_required(o_reinit_required),
	.o_banks_idle(o_banks_idle)
);

/* File: tb/ddr_ctrl_model.sv */
// Purpose: Controller model issuing link commands and fault levels.
// Assumes: Faults are raised only while a burst is pending.
// Notes: Command and bank lines toggle every idle cycle so a stale value is never read.
`timescale 1ns/1ns
module ddr_ctrl_model (
	input wire logic i_ck,
	output logic o_cmd_valid,
	output rw_turn_pkg::cmd_e o_cmd,
	output logic [2:0] o_bank,
	output logic o_a12,
	output logic [2:0] o_faults,
	output logic [3:0] o_shift
);
	import rw_turn_pkg::*;
	logic last_rd = 1'b0;
	initial
	begin
		{o_cmd_valid, o_bank, o_a12, o_faults, o_shift} = '0;
		o_cmd = CMD_DES;
	end
	task automatic idle(input int n);
		repeat (n)
		begin
			@(negedge i_ck);
			o_cmd_valid = 1'b0;
			o_cmd = cmd_e'(~o_cmd);
			o_bank = ~o_bank;
		end
	endtask : idle
	task automatic issue(input cmd_e c, input logic [2:0] b, input logic a, input logic [2:0] f, input logic [3:0] s);
		logic rw;
		rw = c inside {CMD_RD, CMD_RDA, CMD_WR, CMD_WRA};
		// A wide gap on every direction change covers both turnaround minimums.
		idle((rw && (c inside {CMD_RD, CMD_RDA}) != last_rd) ? 32 : 6);
		if (rw)
			last_rd = c inside {CMD_RD, CMD_RDA};
		@(negedge i_ck);
		{o_cmd_valid, o_bank, o_a12} = {1'b1, b, a};
		o_cmd = c;
		idle(6);
		{o_faults, o_shift} = {f, s};
		idle(4);
		o_faults = 3'h0;
	endtask : issue
endmodule : ddr_ctrl_model

/* File: tb/ddr4_rw_turnaround_and_write_fault_bench.sv */
// Purpose: Self-checking bench for the turnaround and write fault tracker.
// Assumes: The controller model spaces commands legally.
// Notes: Write terms are queued at issue and checked at each recovery pulse.
`timescale 1ns/1ns
module ddr4_rw_turnaround_and_write_fault_bench;
	import rw_turn_pkg::*;
	logic i_sys_clk = 0, i_ck = 0, i_rst_n = 0, i_cmd_valid, i_a12, i_wr_preamble_2t = 0, i_wr_crc_en = 0;
	logic i_dq_offset_fault, i_strobe_fault, i_other_fault, o_wr_recovery_start, o_write_suspect;
	logic o_reinit_required, o_banks_idle;
	cmd_e i_cmd;
	logic [2:0] i_bank;
	logic [3:0] i_strobe_shift_edges, i_twtr_s_clks = 4'h3, o_rd_burst_term, o_wr_burst_term, wt, rt;
	logic [1:0] i_burst_mode = 2'h0;
	logic [4:0] i_cas_lat = 5'h0b, i_cas_wr_lat = 5'h09;
	logic [6:0] o_rd_to_wr_min_clks, o_wr_to_rd_min_clks;
	logic [15:0] lfsr = 16'h000d;
	logic [3:0] exp_q[$];
	logic [2:0] faults;
	int n_errors = 0, checks_done = 0, cyc = 0;
	assign {i_other_fault, i_strobe_fault, i_dq_offset_fault} = faults;
	rw_turn_tracker DUT (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_ck(i_ck),
		.i_cmd_valid(i_cmd_valid),
		.i_cmd(i_cmd),
		.i_bank(i_bank),
		.i_a12(i_a12),
		.i_dq_offset_fault(i_dq_offset_fault),
		.i_strobe_fault(i_strobe_fault),
		.i_strobe_shift_edges(i_strobe_shift_edges),
		.i_other_fault(i_other_fault),
		.i_burst_mode(i_burst_mode),
		.i_cas_lat(i_cas_lat),
		.i_cas_wr_lat(i_cas_wr_lat),
		.i_wr_preamble_2t(i_wr_preamble_2t),
		.i_wr_crc_en(i_wr_crc_en),
		.i_twtr_s_clks(i_twtr_s_clks),
		.o_wr_recovery_start(o_wr_recovery_start),
		.o_rd_burst_term(o_rd_burst_term),
		.o_wr_burst_term(o_wr_burst_term),
		.o_rd_to_wr_min_clks(o_rd_to_wr_min_clks),
		.o_wr_to_rd_min_clks(o_wr_to_rd_min_clks),
		.o_write_suspect(o_write_suspect),
		.o_reinit_required(o_reinit_required),
		.o_banks_idle(o_banks_idle)
	);
	ddr_ctrl_model ctrl (.i_ck(i_ck), .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd), .o_bank(i_bank), .o_a12(i_a12),
		.o_faults(faults), .o_shift(i_strobe_shift_edges));
	initial forever #4 i_sys_clk = ~i_sys_clk;
	initial
	begin
		#3;
		forever #15 i_ck = ~i_ck;
	end
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nx
	task automatic chk(input string n, input logic [6:0] e, input logic [6:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("mismatch %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	task automatic stat(input logic s, input logic r, input logic b);
		repeat (48) @(negedge i_sys_clk);
		chk("suspect", 7'(s), 7'(o_write_suspect));
		chk("reinit", 7'(r), 7'(o_reinit_required));
		chk("idle", 7'(b), 7'(o_banks_idle));
	endtask : stat
	task automatic pulse_reset;
		i_rst_n = 0;
		repeat (10) @(negedge i_sys_clk);
		i_rst_n = 1;
		stat(0, 0, 1);
	endtask : pulse_reset
	task automatic wr(input cmd_e c, input logic [2:0] b, input logic a, input logic [2:0] f, input logic [3:0] s);
		exp_q.push_back(i_burst_mode == 2'h2 ? 4'h4 : 4'h8);
		ctrl.issue(c, b, a, f, s);
	endtask : wr
	always @(negedge i_sys_clk)
	begin
		cyc++;
		if (o_wr_recovery_start === 1'b1)
			chk("wr_term", 7'(exp_q.pop_front()), 7'(o_wr_burst_term));
		if (cyc == 40000)
		begin
			n_errors++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (20) @(posedge i_sys_clk);
		@(negedge i_sys_clk) i_rst_n = 1;
		for (int m = 0; m < 4; m++)
		begin
			lfsr = nx(lfsr);
			i_burst_mode = (m == 3) ? 2'h2 : 2'(m > 0);
			i_cas_lat = 5'h0a + lfsr[2:0];
			i_wr_preamble_2t = lfsr[3];
			i_twtr_s_clks = 4'h2 + lfsr[5:4];
			wt = (m == 3) ? 4'h4 : 4'h8;
			rt = (m > 1) ? 4'h4 : 4'h8;
			wr(m % 2 ? CMD_WRA : CMD_WR, lfsr[8:6], lfsr[9], 3'h0, 4'h0);
			ctrl.issue(m % 2 ? CMD_RDA : CMD_RD, lfsr[8:6], m != 2, 3'h0, 4'h0);
			stat(0, 0, 1);
			chk("rd_term", 7'(rt), 7'(o_rd_burst_term));
			chk("rd_to_wr", 7'(i_cas_lat - 9 + rt / 2 + 2 + i_wr_preamble_2t), o_rd_to_wr_min_clks);
			chk("wr_to_rd", 7'(9 + wt / 2 + i_twtr_s_clks), o_wr_to_rd_min_clks);
		end
		$display("test terms done");
		ctrl.issue(CMD_ACT, 3'h1, 1'b0, 3'h0, 4'h0);
		wr(CMD_WR, 3'h1, 1'b1, 3'h2, 4'h6);
		stat(1, 0, 0);
		ctrl.issue(CMD_RD, 3'h1, 1'b0, 3'h0, 4'h0);
		wr(CMD_WR, 3'h1, 1'b1, 3'h1, 4'h0);
		ctrl.issue(CMD_ACT, 3'h6, 1'b0, 3'h0, 4'h0);
		wr(CMD_WR, 3'h6, 1'b1, 3'h0, 4'h0);
		stat(1, 0, 0);
		ctrl.issue(CMD_PRE, 3'h1, 1'b0, 3'h0, 4'h0);
		stat(1, 0, 0);
		ctrl.issue(CMD_PREA, 3'h0, 1'b0, 3'h0, 4'h0);
		stat(0, 0, 1);
		$display("test tolerated done");
		wr(CMD_WR, 3'h2, 1'b1, 3'h2, 4'h7);
		stat(1, 1, 1);
		pulse_reset();
		wr(CMD_WR, 3'h3, 1'b1, 3'h4, 4'h2);
		stat(1, 1, 1);
		pulse_reset();
		i_wr_crc_en = 1;
		wr(CMD_WR, 3'h3, 1'b1, 3'h2, 4'h2);
		stat(1, 1, 1);
		chk("pending", 7'h00, 7'(exp_q.size()));
		$display("test reinit done");
		print_verdict();
	end
endmodule : ddr4_rw_turnaround_and_write_fault_bench
